// ---- shared/depth_video_defines.svh ----
// Register indices, field positions, reset values and fixed counts
// Assumes inclusion by bare name from the package and the core module
`ifndef DEPTH_VIDEO_DEFINES_SVH
`define DEPTH_VIDEO_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_BIN_CFG 8'hd9
`define IDX_LINE_TIMING 8'hdc
`define IDX_FRAME_BLANK 8'hdd
`define IDX_PORT_SELECT 8'hde
`define IDX_TIMING_STATUS 8'he1

// Reset values
`define RST_BIN_CFG 24'h00000c
`define RST_LINE_TIMING 24'h480280
`define RST_FRAME_BLANK 24'h01883c
`define RST_PORT_SELECT 24'h000000

// Field positions
`define F_COL_EXP_HI 21
`define F_COL_EXP_LO 20
`define F_ROW_EXP_HI 19
`define F_ROW_EXP_LO 18
`define F_SHIFT_EN 16
`define F_PRESERVE 15
`define F_AMB_HI 9
`define F_AMB_LO 6
`define F_SHIFT_HI 2
`define F_SHIFT_LO 0
`define F_VPULSE_HI 23
`define F_VPULSE_LO 21
`define F_HBLANK_HI 20
`define F_HBLANK_LO 11
`define F_HACTIVE_HI 10
`define F_HACTIVE_LO 1
`define F_VBLANK_HI 14
`define F_VBLANK_LO 9
`define F_PORT_SEL 4

// Array geometry
`define ARRAY_COLS 7'd80
`define ARRAY_ROWS 8'd60
`define LAST_COL 7'd79

// AHB encodings
`define HTRANS_NONSEQ 2'b10
`define HTRANS_SEQ 2'b11
`define HSIZE_WORD 3'b010

`endif

// ---- shared/depth_video_pkg.sv ----
// Types for the depth binning and video timing block
// Assumes the defines header is on the include path
`include "depth_video_defines.svh"

package depth_video_pkg;

  // One pixel from the depth engine, with line and frame markers
  typedef struct packed {
    logic signed [11:0] i;
    logic signed [11:0] q;
    logic [11:0] phase;
    logic [11:0] amplitude;
    logic [11:0] ambient;
    logic first_of_frame;
    logic last_of_line;
  } pixel_in_t;

  // One binned pixel towards the video port
  typedef struct packed {
    logic signed [24:0] i;
    logic signed [24:0] q;
    logic [11:0] phase;
    logic [17:0] amplitude;
  } pixel_out_t;

  // AHB-Lite slave request fields
  typedef struct packed {
    logic sel;
    logic [31:0] addr;
    logic [1:0] trans;
    logic write;
    logic [2:0] size;
  } ahb_req_t;

endpackage : depth_video_pkg

// ---- core/depth_video_port.sv ----
// Depth pixel binning, I/Q scaling, ambient phase gating and video sync timing
// Assumes an AHB-Lite master on clk and a pixel clock from outside, sampled here
//
// Behaviour
// - Merge two-to-the-field columns per bin
// - Merge two-to-the-field rows per bin
// - Scale I and Q only when enabled
// - Left-shift I and Q by shift field
// - Preserve bit keeps frame size unchanged
// - Low ambient zeroes phase, keeps amplitude
// - Vertical pulse length from three-bit code
// - Horizontal blank lasts line-blank pixel times
// - Horizontal active lasts line-active pixel times
// - Blank lines between vertical pulse and first line
// - Sync timing only in parallel port mode
//
// Design decision made here: register access over AHB-Lite.
`timescale 1ns/1ps
`include "depth_video_defines.svh"

module depth_video_port (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pixel stream from the depth engine
  input wire logic pixel_in_valid,
  input wire depth_video_pkg::pixel_in_t pixel_in,
  // Video port
  input wire logic pixel_clock,
  output logic vertical_sync,
  output logic horizontal_sync,
  output depth_video_pkg::pixel_out_t pixel_out,
  output logic pixel_out_valid
);

  // Register file
  logic [23:0] bin_cfg_r;
  logic [23:0] line_timing_r;
  logic [23:0] frame_blank_r;
  logic [23:0] port_select_r;

  // Bus data phase
  logic wr_pending_r;
  logic [7:0] wr_index_r;
  logic [31:0] rdata_r;

  // Pixel clock synchroniser and edge
  logic pclk_meta_r;
  logic pclk_sync_r;
  logic pclk_prev_r;
  logic pixel_tick;

  // Timing counters
  logic [10:0] h_count_r;
  logic [7:0] v_count_r;

  // Binning state
  logic [6:0] col_idx_r;
  logic [2:0] col_grp_r;
  logic [2:0] row_grp_r;
  logic signed [24:0] acc_i_r;
  logic signed [24:0] acc_q_r;
  logic [17:0] acc_amp_r;
  logic signed [24:0] row_i_mem [0:79];
  logic signed [24:0] row_q_mem [0:79];
  logic [17:0] row_amp_mem [0:79];
  logic signed [24:0] bin_i_mem [0:79];
  logic signed [24:0] bin_q_mem [0:79];
  logic [17:0] bin_amp_mem [0:79];
  logic [11:0] bin_phase_mem [0:79];
  depth_video_pkg::pixel_out_t data_r;

  depth_video_pkg::ahb_req_t req;

  // Number of pixels merged along one axis of a bin, less one
  function automatic logic [2:0] merge_mask(input logic [1:0] exponent);
    case (exponent)
      2'd0: merge_mask = 3'd0;
      2'd1: merge_mask = 3'd1;
      2'd2: merge_mask = 3'd3;
      default: merge_mask = 3'd7;
    endcase
  endfunction : merge_mask

  // Lines in the vertical pulse
  function automatic logic [5:0] pulse_lines(input logic [2:0] code);
    case (code)
      3'd0: pulse_lines = 6'd1;
      3'd1: pulse_lines = 6'd2;
      3'd3: pulse_lines = 6'd8;
      3'd4: pulse_lines = 6'd16;
      3'd5: pulse_lines = 6'd32;
      default: pulse_lines = 6'd4;
    endcase
  endfunction : pulse_lines

  // Field views
  logic [1:0] col_exp;
  logic [1:0] row_exp;
  logic shift_en;
  logic [2:0] shift_amt;
  logic preserve;
  logic [3:0] amb_floor;
  logic [2:0] vpulse_code;
  logic [9:0] hblank;
  logic [9:0] hactive;
  logic [5:0] vblank;
  logic port_serial;
  logic [2:0] col_mask;
  logic [2:0] row_mask;

  assign col_exp = bin_cfg_r[`F_COL_EXP_HI:`F_COL_EXP_LO];
  assign row_exp = bin_cfg_r[`F_ROW_EXP_HI:`F_ROW_EXP_LO];
  assign shift_en = bin_cfg_r[`F_SHIFT_EN];
  assign shift_amt = bin_cfg_r[`F_SHIFT_HI:`F_SHIFT_LO];
  assign preserve = bin_cfg_r[`F_PRESERVE];
  assign amb_floor = bin_cfg_r[`F_AMB_HI:`F_AMB_LO];
  assign vpulse_code = line_timing_r[`F_VPULSE_HI:`F_VPULSE_LO];
  assign hblank = line_timing_r[`F_HBLANK_HI:`F_HBLANK_LO];
  assign hactive = line_timing_r[`F_HACTIVE_HI:`F_HACTIVE_LO];
  assign vblank = frame_blank_r[`F_VBLANK_HI:`F_VBLANK_LO];
  assign port_serial = port_select_r[`F_PORT_SEL];
  assign col_mask = merge_mask(col_exp);
  assign row_mask = merge_mask(row_exp);

  assign req = '{sel: hsel, addr: haddr, trans: htrans, write: hwrite, size: hsize};

  // Bus address phase; always zero wait, always OKAY
  logic addr_valid;
  logic [7:0] addr_index;
  assign addr_valid = req.sel && hready && req.addr[1:0] == 2'b00 &&
                      (req.trans == `HTRANS_NONSEQ || req.trans == `HTRANS_SEQ);
  assign addr_index = req.addr[9:2];

  always_ff @(posedge clk) begin
    if (reset) begin
      wr_pending_r <= 1'b0;
      wr_index_r <= 8'h00;
    end else begin
      wr_pending_r <= addr_valid && req.write;
      wr_index_r <= addr_index;
    end
  end

  // Status view of the timing generator
  logic [31:0] status_word;
  assign status_word = {5'h00, v_count_r, h_count_r, 5'h00, port_serial,
                        horizontal_sync, vertical_sync};

  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_r <= 32'h0000_0000;
    end else if (addr_valid && !req.write) begin
      if (addr_index == `IDX_BIN_CFG) begin
        rdata_r <= {8'h00, bin_cfg_r};
      end else if (addr_index == `IDX_LINE_TIMING) begin
        rdata_r <= {8'h00, line_timing_r};
      end else if (addr_index == `IDX_FRAME_BLANK) begin
        rdata_r <= {8'h00, frame_blank_r};
      end else if (addr_index == `IDX_PORT_SELECT) begin
        rdata_r <= {8'h00, port_select_r};
      end else if (addr_index == `IDX_TIMING_STATUS) begin
        rdata_r <= status_word;
      end else begin
        rdata_r <= 32'h0000_0000;
      end
    end
  end

  assign hrdata = rdata_r;

  always_ff @(posedge clk) begin
    if (reset) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Reserved bits are stored as written; keeping them legal is up to software
  always_ff @(posedge clk) begin
    if (reset) begin
      bin_cfg_r <= `RST_BIN_CFG;
      line_timing_r <= `RST_LINE_TIMING;
      frame_blank_r <= `RST_FRAME_BLANK;
      port_select_r <= `RST_PORT_SELECT;
    end else if (wr_pending_r) begin
      if (wr_index_r == `IDX_BIN_CFG) begin
        bin_cfg_r <= hwdata[23:0];
      end else if (wr_index_r == `IDX_LINE_TIMING) begin
        line_timing_r <= hwdata[23:0];
      end else if (wr_index_r == `IDX_FRAME_BLANK) begin
        frame_blank_r <= hwdata[23:0];
      end else if (wr_index_r == `IDX_PORT_SELECT) begin
        port_select_r <= hwdata[23:0];
      end
    end
  end

  // Two flops before the edge detector; the edge lags the pin by 2-3 cycles
  always_ff @(posedge clk) begin
    if (reset) begin
      pclk_meta_r <= 1'b0;
      pclk_sync_r <= 1'b0;
      pclk_prev_r <= 1'b0;
    end else begin
      pclk_meta_r <= pixel_clock;
      pclk_sync_r <= pclk_meta_r;
      pclk_prev_r <= pclk_sync_r;
    end
  end

  assign pixel_tick = pclk_sync_r && !pclk_prev_r;

  // Frame geometry in lines
  logic [5:0] vpulse_len;
  logic [7:0] active_lines;
  logic [7:0] first_active;
  logic [7:0] last_line;
  logic [10:0] line_len;
  assign vpulse_len = pulse_lines(vpulse_code);
  assign active_lines = preserve ? `ARRAY_ROWS : `ARRAY_ROWS >> row_exp;
  assign first_active = {2'b00, vpulse_len} + {2'b00, vblank};
  assign last_line = first_active + active_lines - 8'd1;
  assign line_len = {1'b0, hactive} + {1'b0, hblank};

  // Line counter advances one per pixel time, frame counter one per line
  always_ff @(posedge clk) begin
    if (reset) begin
      h_count_r <= 11'h000;
      v_count_r <= 8'h00;
    end else if (port_serial) begin
      h_count_r <= 11'h000;
      v_count_r <= 8'h00;
    end else if (pixel_tick) begin
      if (h_count_r >= line_len - 11'd1) begin
        h_count_r <= 11'h000;
        v_count_r <= (v_count_r >= last_line) ? 8'h00 : v_count_r + 8'd1;
      end else begin
        h_count_r <= h_count_r + 11'd1;
      end
    end
  end

  // Sync outputs, both low while the serial port is selected
  always_ff @(posedge clk) begin
    if (reset) begin
      vertical_sync <= 1'b0;
      horizontal_sync <= 1'b0;
    end else if (port_serial) begin
      vertical_sync <= 1'b0;
      horizontal_sync <= 1'b0;
    end else begin
      vertical_sync <= v_count_r < {2'b00, vpulse_len};
      horizontal_sync <= v_count_r >= first_active && v_count_r <= last_line &&
                         h_count_r < {1'b0, hactive};
    end
  end

  // Scaling and ambient gating of the incoming pixel
  logic signed [18:0] scaled_i;
  logic signed [18:0] scaled_q;
  logic [11:0] gated_phase;
  always_comb begin
    scaled_i = 19'(pixel_in.i);
    scaled_q = 19'(pixel_in.q);
    if (shift_en) begin
      scaled_i = scaled_i <<< shift_amt;
      scaled_q = scaled_q <<< shift_amt;
    end
    gated_phase = (pixel_in.ambient < {8'h00, amb_floor}) ? 12'h000 : pixel_in.phase;
  end

  // Column accumulation
  logic col_done;
  logic row_done;
  logic [6:0] bin_col;
  logic signed [24:0] sum_i;
  logic signed [24:0] sum_q;
  logic [17:0] sum_amp;
  logic signed [24:0] tot_i;
  logic signed [24:0] tot_q;
  logic [17:0] tot_amp;
  assign col_done = col_grp_r == col_mask;
  assign row_done = row_grp_r == row_mask;
  assign bin_col = col_idx_r >> col_exp;
  assign sum_i = (col_grp_r == 3'd0 ? 25'sd0 : acc_i_r) + 25'(scaled_i);
  assign sum_q = (col_grp_r == 3'd0 ? 25'sd0 : acc_q_r) + 25'(scaled_q);
  assign sum_amp = (col_grp_r == 3'd0 ? 18'd0 : acc_amp_r) + {6'h00, pixel_in.amplitude};
  assign tot_i = (row_grp_r == 3'd0 ? 25'sd0 : row_i_mem[bin_col]) + sum_i;
  assign tot_q = (row_grp_r == 3'd0 ? 25'sd0 : row_q_mem[bin_col]) + sum_q;
  assign tot_amp = (row_grp_r == 3'd0 ? 18'd0 : row_amp_mem[bin_col]) + sum_amp;

  always_ff @(posedge clk) begin
    if (reset) begin
      col_idx_r <= 7'd0;
      col_grp_r <= 3'd0;
      row_grp_r <= 3'd0;
      acc_i_r <= 25'sd0;
      acc_q_r <= 25'sd0;
      acc_amp_r <= 18'd0;
    end else if (pixel_in_valid) begin
      acc_i_r <= sum_i;
      acc_q_r <= sum_q;
      acc_amp_r <= sum_amp;
      if (pixel_in.last_of_line || col_idx_r == `LAST_COL) begin
        col_idx_r <= 7'd0;
        col_grp_r <= 3'd0;
        row_grp_r <= row_done ? 3'd0 : row_grp_r + 3'd1;
      end else begin
        col_idx_r <= col_idx_r + 7'd1;
        col_grp_r <= col_done ? 3'd0 : col_grp_r + 3'd1;
      end
      if (pixel_in.first_of_frame) begin
        col_idx_r <= 7'd1;
        col_grp_r <= (col_mask == 3'd0) ? 3'd0 : 3'd1;
        row_grp_r <= 3'd0;
      end
    end
  end

  // Row sums and finished bins held per output column
  always_ff @(posedge clk) begin
    if (pixel_in_valid && col_done) begin
      row_i_mem[bin_col] <= tot_i;
      row_q_mem[bin_col] <= tot_q;
      row_amp_mem[bin_col] <= tot_amp;
      if (row_done) begin
        bin_i_mem[bin_col] <= tot_i;
        bin_q_mem[bin_col] <= tot_q;
        bin_amp_mem[bin_col] <= tot_amp;
        bin_phase_mem[bin_col] <= gated_phase;
      end
    end
  end

  // Reduced frames emit one word per bin; preserved frames one per pixel,
  // replaying the last finished bin of that column, so rows lag one group
  always_ff @(posedge clk) begin
    if (reset) begin
      data_r <= '0;
      pixel_out_valid <= 1'b0;
    end else begin
      pixel_out_valid <= 1'b0;
      if (pixel_in_valid && !preserve && col_done && row_done) begin
        data_r <= '{i: tot_i, q: tot_q, phase: gated_phase, amplitude: tot_amp};
        pixel_out_valid <= 1'b1;
      end else if (pixel_in_valid && preserve) begin
        data_r <= '{i: bin_i_mem[bin_col], q: bin_q_mem[bin_col],
                    phase: bin_phase_mem[bin_col], amplitude: bin_amp_mem[bin_col]};
        pixel_out_valid <= 1'b1;
      end
    end
  end

  assign pixel_out = data_r;

endmodule : depth_video_port

// ---- tb/depth_video_port_chk.sv ----
// Port checker for the depth video block
// Assumes config is written only while no pixels flow
`timescale 1ns/1ps
module depth_video_port_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pixels and video
  input wire logic pixel_in_valid,
  input wire depth_video_pkg::pixel_in_t pixel_in,
  input wire logic vertical_sync,
  input wire logic horizontal_sync,
  input wire depth_video_pkg::pixel_out_t pixel_out,
  input wire logic pixel_out_valid
);
  logic wr_r;
  logic [31:0] wa_r;
  logic [23:0] cfg_r;
  logic port_r;
  logic plain;
  // Config shadow, so pixel checks know the mode
  always_ff @(posedge clk) begin
    wa_r <= haddr;
    if (reset) begin
      wr_r <= 1'b0;
      cfg_r <= 24'h00000c;
      port_r <= 1'b0;
    end else begin
      wr_r <= hsel && hready && hwrite && htrans[1];
      if (wr_r && wa_r == 32'h364) cfg_r <= hwdata[23:0];
      if (wr_r && wa_r == 32'h378) port_r <= hwdata[4];
    end
  end
  assign plain = pixel_in_valid && cfg_r[21:18] == 4'h0 && !cfg_r[15];
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  property p_ready; hreadyout && !hresp; endproperty
  a_ready: assert property (p_ready) else $error("bus stalled or error");
  property p_rst; disable iff (1'b0) reset |=> !vertical_sync && !pixel_out_valid; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_excl; !(vertical_sync && horizontal_sync); endproperty
  a_excl: assert property (p_excl) else $error("line sync inside frame pulse");
  property p_port; port_r && $past(port_r, 4) |-> !vertical_sync && !horizontal_sync; endproperty
  a_port: assert property (p_port) else $error("sync while serial selected");
  property p_hold; !pixel_out_valid |-> $stable(pixel_out); endproperty
  a_hold: assert property (p_hold) else $error("pixel out moved without valid");
  property p_keep; pixel_in_valid && cfg_r[15] |=> pixel_out_valid; endproperty
  a_keep: assert property (p_keep) else $error("pixel dropped in keep mode");
  property p_noscale; plain && !cfg_r[16] |=> pixel_out.i == 25'($past(pixel_in.i)); endproperty
  a_noscale: assert property (p_noscale) else $error("i scaled while off");
  property p_shift;
    plain && cfg_r[16] |=> pixel_out.q == 25'($past(pixel_in.q)) <<< cfg_r[2:0];
  endproperty
  a_shift: assert property (p_shift) else $error("q shift wrong");
  property p_amb;
    plain && pixel_in.ambient < {8'h0, cfg_r[9:6]} |=> pixel_out.phase == 12'h0 &&
      pixel_out.amplitude == {6'h0, $past(pixel_in.amplitude)};
  endproperty
  a_amb: assert property (p_amb) else $error("dark pixel phase kept");
  c_keep: cover property (pixel_in_valid && cfg_r[15]);
  c_shift: cover property (plain && cfg_r[16]);
  c_frame: cover property ($fell(vertical_sync));
endmodule : depth_video_port_chk

// ---- tb/video_host_model.sv ----
// Video host: makes the pixel clock, measures sync timing
// Assumes syncs settle within one pixel time
`timescale 1ns/1ps
module video_host_model (
  // Control
  input wire logic run,
  // Video port
  output logic pixel_clock,
  input wire logic vertical_sync,
  input wire logic horizontal_sync,
  // Measured pixel times and lines
  output int hs_len,
  output int hb_len,
  output int vs_len,
  output int vb_len,
  output int act_lines
);
  int pc = 0;
  int nl = 0;
  logic vs_d = 1'b0;
  logic hs_d = 1'b0;
  logic first = 1'b0;
  // Stands low while stopped, so no stray edge
  initial begin
    pixel_clock = 1'b0;
    forever begin
      #200;
      pixel_clock = run ? ~pixel_clock : 1'b0;
    end
  end
  always @(posedge pixel_clock) begin
    vs_d <= vertical_sync;
    hs_d <= horizontal_sync;
    pc <= (vertical_sync != vs_d || horizontal_sync != hs_d) ? 1 : pc + 1;
    if (vs_d && !vertical_sync) begin
      vs_len <= pc;
      first <= 1'b1;
    end
    if (hs_d && !horizontal_sync) hs_len <= pc;
    if (!hs_d && horizontal_sync) begin
      if (first) vb_len <= pc;
      else hb_len <= pc;
      first <= 1'b0;
      nl <= nl + 1;
    end
    if (!vs_d && vertical_sync) begin
      act_lines <= nl;
      nl <= 0;
    end
  end
endmodule : video_host_model

// ---- tb/depth_video_port_tb_top.sv ----
// Bench: registers, pixel binning and sync timing
// Assumes the host model makes the pixel clock
`timescale 1ns/1ps
module depth_video_port_tb_top;
  logic clk, reset, hsel, hwrite, pixel_in_valid, run, hreadyout, hresp;
  logic pixel_clock, vertical_sync, horizontal_sync, pixel_out_valid;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  depth_video_pkg::pixel_in_t pixel_in;
  depth_video_pkg::pixel_out_t pixel_out, last_r;
  int n_errors = 0;
  int num_checks = 0;
  int n_out = 0;
  int hs_len, hb_len, vs_len, vb_len, act_lines;
  int lines_t[8] = '{1, 2, 4, 8, 16, 32, 4, 4};
  logic [31:0] ra[5] = '{32'h364, 32'h370, 32'h374, 32'h378, 32'h3fc};
  logic [31:0] rv[5] = '{32'hc, 32'h480280, 32'h1883c, 32'h0, 32'h0};
  logic [23:0] c_t[5] = '{24'h8, 24'h1000b, 24'h1000f, 24'h148, 24'h148};
  logic [11:0] a_t[5] = '{12'hfff, 12'hfff, 12'hfff, 12'h4, 12'h5};
  logic [24:0] i_t[5] = '{25'h1fffffb, 25'h1ffffd8, 25'h1fffd80, 25'h1fffffb, 25'h1fffffb};
  logic [24:0] q_t[5] = '{25'h7, 25'h38, 25'h380, 25'h7, 25'h7};
  logic [11:0] p_t[5] = '{12'h5a5, 12'h5a5, 12'h5a5, 12'h0, 12'h5a5};
  depth_video_port depth_video_port_inst (.clk, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .pixel_in_valid, .pixel_in,
    .pixel_clock, .vertical_sync, .horizontal_sync, .pixel_out, .pixel_out_valid);
  video_host_model video_host_model_inst (.run, .pixel_clock, .vertical_sync,
    .horizontal_sync, .hs_len, .hb_len, .vs_len, .vb_len, .act_lines);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize
  task automatic bus(input logic w, input logic [31:0] a, wd, output logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : bus
  task automatic pix(input logic [11:0] iv, amb, input logic fof, lol);
    @(posedge clk);
    pixel_in_valid <= 1'b1;
    pixel_in <= '{iv, 12'h7, 12'h5a5, 12'ha0, amb, fof, lol};
  endtask : pix
  task automatic idle;
    @(posedge clk);
    pixel_in_valid <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : idle
  // Raster rows with i = row + column
  task automatic rows(input int nr, en, input logic [24:0] ei, input logic ck);
    int n0;
    n0 = n_out;
    for (int r = 0; r < nr; r++) begin
      for (int c = 0; c < 80; c++) pix(12'(r + c), 12'hfff, r == 0 && c == 0, c == 79);
    end
    idle();
    chk("bins", 32'(en), 32'(n_out - n0));
    if (ck) chk("bin i", {7'h0, ei}, {7'h0, last_r.i});
  endtask : rows
  // Bounded wait, long enough for the longest test frame
  task automatic vs_rise;
    int k;
    k = 0;
    while (vertical_sync === 1'b1 && k < 9000) begin
      @(posedge clk);
      k++;
    end
    while (vertical_sync !== 1'b1 && k < 9000) begin
      @(posedge clk);
      k++;
    end
    // Host samples on its own slower clock; let it see the rise first
    repeat (12) @(posedge clk);
    chk("vsync rise", 32'h1, 32'(k < 9000));
  endtask : vs_rise
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #5000000;
    n_errors++;
    $display("CHECK FAILED run expected end seen timeout");
    summarize();
  end
  always @(posedge clk) begin
    if (pixel_out_valid) begin
      n_out <= n_out + 1;
      last_r <= pixel_out;
    end
  end
  initial begin
    reset = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata, pixel_in_valid, run} = '0;
    hsize = 3'h2;
    pixel_in = '0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    bus(1'b1, 32'h3fc, 32'hffffffff, rd);
    foreach (ra[k]) begin
      bus(1'b0, ra[k], 32'h0, rd);
      chk("reset value", rv[k], rd);
    end
    for (int k = 0; k < 5; k++) begin
      bus(1'b1, 32'h364, {8'h0, c_t[k]}, rd);
      pix(12'hffb, a_t[k], 1'b1, 1'b0);
      idle();
      chk("i", {7'h0, i_t[k]}, {7'h0, last_r.i});
      chk("q", {7'h0, q_t[k]}, {7'h0, last_r.q});
      chk("phase", {20'h0, p_t[k]}, {20'h0, last_r.phase});
      chk("amplitude", 32'ha0, {14'h0, last_r.amplitude});
    end
    bus(1'b1, 32'h364, 32'h100008, rd);
    rows(1, 40, 25'h9d, 1'b1);
    bus(1'b1, 32'h364, 32'h40008, rd);
    rows(2, 80, 25'h9f, 1'b1);
    bus(1'b1, 32'h364, 32'h140008, rd);
    rows(2, 40, 25'h13c, 1'b1);
    bus(1'b1, 32'h364, 32'h108008, rd);
    rows(2, 160, 25'h0, 1'b0);
    run <= 1'b1;
    for (int c = 0; c < 8; c++) begin
      bus(1'b1, 32'h370, {8'h0, 3'(c), 10'h2, 10'h3, 1'b0}, rd);
      bus(1'b1, 32'h374, {8'h0, 9'h3, 6'(c + 2), 9'h3c}, rd);
      vs_rise();
      vs_rise();
      chk("vsync", 32'(lines_t[c] * 5), 32'(vs_len));
      chk("vblank", 32'((c + 2) * 5), 32'(vb_len));
      chk("hactive", 32'h3, 32'(hs_len));
      chk("hblank", 32'h2, 32'(hb_len));
      chk("lines", 32'h3c, 32'(act_lines));
    end
    bus(1'b1, 32'h364, 32'h40008, rd);
    vs_rise();
    vs_rise();
    chk("reduced lines", 32'h1e, 32'(act_lines));
    bus(1'b1, 32'h378, 32'h10, rd);
    bus(1'b0, 32'h384, 32'h0, rd);
    bus(1'b0, 32'h384, 32'h0, rd);
    chk("status", 32'h4, rd & 32'h7);
    bus(1'b1, 32'h378, 32'h0, rd);
    vs_rise();
    summarize();
  end
endmodule : depth_video_port_tb_top
bind depth_video_port depth_video_port_chk depth_video_port_chk_inst (.clk, .reset, .hsel,
  .haddr, .htrans, .hwrite, .hready, .hwdata, .hreadyout, .hresp, .pixel_in_valid, .pixel_in,
  .vertical_sync, .horizontal_sync, .pixel_out, .pixel_out_valid);
